/* logic/tccm_defines.vh */
// constants for the timer channel clock and mode control block
`ifndef TCCM_DEFINES_VH
`define TCCM_DEFINES_VH
`define TCCM_IDX_CLK_CTRL   16'hFEA0
`define TCCM_IDX_MODE       16'hFEA1
// byte address is four times the index; only its low byte is decoded
`define TCCM_OFF_CLK_CTRL   8'h80
`define TCCM_OFF_MODE       8'h84
`define TCCM_OFF_SYNC       8'h88
`define TCCM_OFF_STATUS     8'h8C
`define TCCM_CTRL_RESET     8'h00
`define TCCM_MODE_RESET     8'hC0
`define TCCM_MODE_RD_MASK   8'hF0
`define TCCM_CLR_LSB        5
`define TCCM_EDGE_LSB       3
`define TCCM_PSC_LSB        0
`define TCCM_MODE_NORMAL    3'h0
`define TCCM_MODE_RSVD      3'h1
`define TCCM_MODE_PWM1      3'h2
`define TCCM_MODE_PWM2      3'h3
`define TCCM_PSC_DIV1       3'h0
`define TCCM_PSC_DIV4       3'h1
`define TCCM_PSC_DIV16      3'h2
`define TCCM_PSC_DIV64      3'h3
`define TCCM_PSC_EXT_A      3'h4
`define TCCM_PSC_EXT_C      3'h5
`define TCCM_PSC_DIV256     3'h6
`define TCCM_PSC_EXT_D      3'h7
`define TCCM_DIV_W          8
`endif

/* logic/tccm_edge_det.v */
// synchronised edge detector for one external count pin
`timescale 1ns/1ps
`default_nettype none
module tccm_edge_det (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       pin,
  output wire       rise,
  output wire       fall
);
  reg [2:0] sync_r;
  // sync_r[0] only feeds sync_r[1]; edges compare stages 1 and 2
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_r <= 3'h0;
    end else if (ce) begin
      sync_r <= {sync_r[1:0], pin};
    end
  end
  assign rise = sync_r[1] & ~sync_r[2];
  assign fall = ~sync_r[1] & sync_r[2];
endmodule // tccm_edge_det
`default_nettype wire

/* logic/tccm_ctrl.v */
// clock select, clear select and mode control for one timer channel
// Function
// RULE1 - clear field 00 never clears, 01 clears on register A match or capture.
// RULE2 - clear field 10 clears on register B match or capture.
// RULE3 - clear field 11 clears when a synchronised channel clears its counter.
// RULE4 - the channel joins synchronous operation only with its sync bit set.
// RULE5 - mode 000 normal, 001 reserved, 010/011 PWM 1/2, 1xx phase modes 1-4.
// RULE6 - software writes 0 to the top mode bit, which is reserved.
// RULE7 - in phase counting the prescaler and edge settings are ignored.
// RULE8 - prescaler picks div 1/4/16/64, pins A/C, div 256, pin D; edge picks rise/fall/both.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "tccm_defines.vh"
module tccm_ctrl (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        external_clock_pin_a,
  input  wire        external_clock_pin_c,
  input  wire        external_clock_pin_d,
  input  wire        match_a,
  input  wire        match_b,
  input  wire        sync_clear_in,
  output reg         count_enable,
  output reg         counter_clear,
  output reg         sync_clear_out,
  output reg  [2:0]  active_mode,
  output reg         phase_counting,
  output reg         pwm_mode
);
  reg  [7:0]  ctrl_r;
  reg  [3:0]  mode_r;
  reg         sync_en_r;
  reg  [7:0]  div_r;
  reg  [7:0]  div_q_r;
  reg  [31:0] awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         aw_have_r;
  reg         w_have_r;
  reg  [31:0] rdata_nxt;
  reg         ext_tick;
  reg         int_tick;
  reg         clr_nxt;
  wire [1:0]  counter_clear_select;
  wire [1:0]  count_edge_select;
  wire [2:0]  prescaler_select;
  wire        a_rise;
  wire        a_fall;
  wire        c_rise;
  wire        c_fall;
  wire        d_rise;
  wire        d_fall;
  wire        wr_go;
  wire        is_phase;
  wire [7:0]  div_rise;

  assign counter_clear_select = ctrl_r[`TCCM_CLR_LSB+1:`TCCM_CLR_LSB];
  assign count_edge_select    = ctrl_r[`TCCM_EDGE_LSB+1:`TCCM_EDGE_LSB];
  assign prescaler_select     = ctrl_r[`TCCM_PSC_LSB+2:`TCCM_PSC_LSB];
  assign is_phase             = mode_r[2];
  assign div_rise             = div_r & ~div_q_r;

  // edge picked by the edge select field
  function edge_pick;
    input [1:0] sel;
    input       r;
    input       f;
    begin
      if (sel[1]) begin
        edge_pick = r | f;
      end else if (sel[0]) begin
        edge_pick = f;
      end else begin
        edge_pick = r;
      end
    end
  endfunction

  tccm_edge_det u_pin_a (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .pin     (external_clock_pin_a),
    .rise    (a_rise),
    .fall    (a_fall)
  );
  tccm_edge_det u_pin_c (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .pin     (external_clock_pin_c),
    .rise    (c_rise),
    .fall    (c_fall)
  );
  tccm_edge_det u_pin_d (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .pin     (external_clock_pin_d),
    .rise    (d_rise),
    .fall    (d_fall)
  );

  // free running divider; prescaled ticks are its bit edges
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      div_r   <= 8'h00;
      div_q_r <= 8'h00;
    end else if (ce) begin
      div_r   <= div_r + 8'h01;
      div_q_r <= div_r;
    end
  end

  always @* begin
    int_tick = 1'b0;
    ext_tick = 1'b0;
    case (prescaler_select) // [RULE8]
      `TCCM_PSC_DIV1:   int_tick = 1'b1;
      `TCCM_PSC_DIV4:   int_tick = div_rise[1];
      `TCCM_PSC_DIV16:  int_tick = div_rise[3];
      `TCCM_PSC_DIV64:  int_tick = div_rise[5];
      `TCCM_PSC_DIV256: int_tick = div_rise[7];
      `TCCM_PSC_EXT_A:  ext_tick = edge_pick(count_edge_select, a_rise, a_fall);
      `TCCM_PSC_EXT_C:  ext_tick = edge_pick(count_edge_select, c_rise, c_fall);
      `TCCM_PSC_EXT_D:  ext_tick = edge_pick(count_edge_select, d_rise, d_fall);
      default:          int_tick = 1'b0;
    endcase
  end

  always @* begin
    case (counter_clear_select)
      2'h0:    clr_nxt = 1'b0; // [RULE1]
      2'h1:    clr_nxt = match_a; // [RULE1]
      2'h2:    clr_nxt = match_b; // [RULE2]
      // only a synchronised channel follows the shared clear
      2'h3:    clr_nxt = sync_en_r & sync_clear_in; // [RULE3] [RULE4]
      default: clr_nxt = 1'b0;
    endcase
  end

  // channel outputs, all registered
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      count_enable   <= 1'b0;
      counter_clear  <= 1'b0;
      sync_clear_out <= 1'b0;
      active_mode    <= `TCCM_MODE_NORMAL;
      phase_counting <= 1'b0;
      pwm_mode       <= 1'b0;
    end else if (ce) begin
      // phase counting counts from the two-phase inputs elsewhere
      count_enable   <= ~is_phase & (int_tick | ext_tick); // [RULE7]
      counter_clear  <= clr_nxt;
      sync_clear_out <= sync_en_r & clr_nxt; // [RULE4]
      active_mode    <= mode_r[2:0]; // [RULE5]
      phase_counting <= is_phase; // [RULE5] [RULE7]
      pwm_mode       <= (mode_r[2:0] == `TCCM_MODE_PWM1) |
                        (mode_r[2:0] == `TCCM_MODE_PWM2); // [RULE5]
    end
  end

  // AXI4-Lite write: address and data in either order
  assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 32'h0;
      wdata_r       <= 32'h0;
      wstrb_r       <= 4'h0;
      ctrl_r        <= `TCCM_CTRL_RESET;
      mode_r        <= 4'h0;
      sync_en_r     <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        aw_have_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_have_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        if (wstrb_r[0]) begin
          case (awaddr_r[7:0])
            `TCCM_OFF_CLK_CTRL: ctrl_r <= {1'b0, wdata_r[6:0]};
            // top mode bit is held; a 1 written there is dropped
            `TCCM_OFF_MODE:     mode_r <= {1'b0, wdata_r[2:0]}; // [RULE6]
            `TCCM_OFF_SYNC:     sync_en_r <= wdata_r[0]; // [RULE4]
            `TCCM_OFF_STATUS:   s_axi_bresp <= 2'h0;
            default:            s_axi_bresp <= 2'h2;
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @* begin
    case (s_axi_araddr[7:0])
      `TCCM_OFF_CLK_CTRL: rdata_nxt = {24'h0, ctrl_r};
      `TCCM_OFF_MODE:     rdata_nxt = {24'h0,
                                       (`TCCM_MODE_RESET & `TCCM_MODE_RD_MASK) |
                                       {4'h0, mode_r}};
      `TCCM_OFF_SYNC:     rdata_nxt = {31'h0, sync_en_r};
      `TCCM_OFF_STATUS:   rdata_nxt = {25'h0, pwm_mode, phase_counting,
                                       counter_clear, active_mode,
                                       count_enable};
      default:            rdata_nxt = 32'h0;
    endcase
  end

  // AXI4-Lite read: one cycle to the answer
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdata_nxt;
        case (s_axi_araddr[7:0])
          `TCCM_OFF_CLK_CTRL, `TCCM_OFF_MODE,
          `TCCM_OFF_SYNC, `TCCM_OFF_STATUS: s_axi_rresp <= 2'h0;
          default:                          s_axi_rresp <= 2'h2;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // tccm_ctrl
`default_nettype wire

/* testbench/tccm_ctrl_checker.sv */
// port-level assertions for the timer channel control block
`timescale 1ns/1ps
`default_nettype none
module tccm_ctrl_checker (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       ce,
  input wire logic       match_a,
  input wire logic       match_b,
  input wire logic       sync_clear_in,
  input wire logic       count_enable,
  input wire logic       counter_clear,
  input wire logic       sync_clear_out,
  input wire logic [2:0] active_mode,
  input wire logic       phase_counting,
  input wire logic       pwm_mode,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  no_tick_a: assert property (phase_counting |-> !count_enable)
    else $error("count tick in phase mode");
  phase_dec_a: assert property (phase_counting == active_mode[2])
    else $error("phase flag wrong");
  pwm_dec_a: assert property (pwm_mode == (active_mode[2:1] == 2'b01))
    else $error("pwm flag wrong");
  clr_cause_a: assert property (counter_clear |->
    $past(ce && (match_a || match_b || sync_clear_in)))
    else $error("clear without cause");
  sync_out_a: assert property (sync_clear_out |-> counter_clear)
    else $error("sync clear without clear");
  rd_ans_a: assert property (ce && s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during response");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready during response");
  cover property (counter_clear);
  cover property (sync_clear_out);
  cover property (pwm_mode ##1 phase_counting);
endmodule // tccm_ctrl_checker
bind tccm_ctrl tccm_ctrl_checker u_chk (.*);
`default_nettype wire

/* testbench/tccm_ctrl_tb_top.sv */
// self-checking bench for the timer channel control block
`timescale 1ns/1ps
`default_nettype none
module tccm_ctrl_tb_top;
  logic        ref_clk = 0;
  logic        rst_n = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        match_a = 0, match_b = 0, sync_clear_in = 0;
  logic [7:0]  pc = 0;
  // pins from one counter: a, c, d differ in rate so a wrong pick shows
  logic        ce = 1'b1;
  wire         external_clock_pin_a = pc[3];
  wire         external_clock_pin_c = pc[2];
  wire         external_clock_pin_d = pc[4];
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, count_enable, counter_clear, sync_clear_out;
  wire         phase_counting, pwm_mode;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [2:0]   active_mode;
  int          fail_count = 0, comparisons = 0;
  logic [31:0] d;
  logic [1:0]  r;

  tccm_ctrl DUT (.*);

  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) pc <= pc + 8'h01;

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task t_reset;
    rd(8'h80);
    chk("ctl_reset", 32'h0, d);
    rd(8'h84);
    chk("mode_reset", 32'hC0, d);
    wr(8'hB0, 8'h05);
    chk("bresp_unmapped", 32'h2, r);
    rd(8'hB0);
    chk("rresp_unmapped", 32'h2, r);
  endtask

  task t_mode;
    for (int i = 0; i < 8; i++) begin
      wr(8'h84, 8'(i));
      repeat (2) @(posedge ref_clk);
      #1 chk("active_mode", i, active_mode);
      chk("pwm_mode", i == 2 || i == 3, pwm_mode);
      chk("phase_counting", i > 3, phase_counting);
      rd(8'h84);
      chk("mode_reg", 8'hC0 | i, d);
    end
    wr(8'h84, 8'h0A);
    rd(8'h84);
    chk("mode_top_bit", 32'hC2, d);
  endtask

  // low clock enable must hold the clear output despite a match
  task t_freeze;
    wr(8'h84, 8'h00);
    wr(8'h80, 8'h20);
    @(posedge ref_clk);
    ce <= 1'b0;
    match_a <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk("frozen_clear", 32'h0, counter_clear);
    @(posedge ref_clk);
    ce <= 1'b1;
    match_a <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("thawed_clear", 32'h0, counter_clear);
  endtask

  task t_clear;
    for (int s = 0; s < 2; s++) begin
      wr(8'h88, 8'(s));
      for (int c = 0; c < 4; c++) begin
        wr(8'h80, 8'(c << 5));
        for (int m = 0; m < 3; m++) begin
          @(posedge ref_clk);
          {sync_clear_in, match_b, match_a} <= 3'(1 << m);
          @(posedge ref_clk);
          {sync_clear_in, match_b, match_a} <= 3'b000;
          #1 chk("clear", c == m + 1 && (c < 3 || s == 1), counter_clear);
          chk("sync_out", s == 1 && c == m + 1, sync_clear_out);
        end
      end
    end
  endtask

  // ticks over 256 cycles once settled; periodic sources give exact counts
  task cnt(input logic [7:0] c, input logic [7:0] m, input int e);
    int n;
    n = 0;
    wr(8'h84, m);
    wr(8'h80, c);
    repeat (8) @(posedge ref_clk);
    repeat (256) begin
      @(posedge ref_clk);
      #1 n += count_enable;
    end
    chk("ticks", e, n);
  endtask

  task t_count;
    int e[8] = '{256, 64, 16, 4, 16, 32, 1, 8};
    for (int i = 0; i < 8; i++) cnt(8'(i), 8'h00, e[i]);
    cnt(8'h0C, 8'h00, 16);
    cnt(8'h14, 8'h00, 32);
    cnt(8'h00, 8'h04, 0);
  endtask

  task complete_run;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #400000;
    fail_count++;
    complete_run;
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_mode;
    t_clear;
    t_freeze;
    t_count;
    complete_run;
  end
endmodule // tccm_ctrl_tb_top
`default_nettype wire
